// ### rtl/msr_pkg.sv
// Types shared by the step and spare register slice.
package msr_pkg;

	// Gain selection codes of the last sequencer step.
	typedef enum logic [1:0] {
		MSR_GAIN_X1  = 2'h0,
		MSR_GAIN_X2  = 2'h1,
		MSR_GAIN_X4A = 2'h2,
		MSR_GAIN_X4B = 2'h3
	} msr_gain_type;

	// Whole state of the register slice.
	typedef struct packed {
		logic         cfg_en;
		msr_gain_type cfg_gain;
		logic         cfg_neg;
		logic [3:0]   cfg_pos;
		logic [1:0]   sp1_hi;
		logic [1:0]   sp1_lo;
		logic [15:0]  sp2;
		logic         ack;
		logic [31:0]  rdata;
		logic         out_en;
		logic [2:0]   out_gain;
		logic         out_neg_ch7;
		logic         out_auto;
		logic [3:0]   out_pos;
	} msr_state_type;

endpackage

// ### rtl/msr_regbank.sv
// Wishbone register slice for the last sequencer step and two spare words.
//
// Behaviour
// - Bit 15 enables sequencer step 15, reset 0.
// - Gain codes 00/01/1x give gain 1/2/4.
// - Step word bits 12:5 always read zero.
// - Bit 4 picks ground or channel 7.
// - Positive codes 0..7 pick analog inputs 0..7.
// - Codes 8..15 pick internal sources, auto negative.
// - Auto negative input overrides negative selection bit.
// - Reset: positive field 1111b, spare one bits 5:4 01b, others zero.
// - Spare one bits 11:10, 5:4 writable storage.
// - Spare one fixed bits read 1000b, 0000b.
// - Spare two has sixteen plain storage bits.
`include "msr_regs.svh"

module msr_regbank #(
	parameter int AW = 10
) (
	input  wire logic          clk_i,         // 250 MHz clock.
	input  wire logic          rst_i,         // Synchronous reset, active high.
	input  wire logic [AW-1:0] adr_i,         // Byte address.
	input  wire logic [31:0]   dat_i,         // Write data.
	input  wire logic [3:0]    sel_i,         // Byte lane selects.
	input  wire logic          we_i,          // Write enable.
	input  wire logic          cyc_i,         // Bus cycle.
	input  wire logic          stb_i,         // Strobe.
	output logic [31:0]        dat_o,         // Read data.
	output logic               ack_o,         // Acknowledge.
	output logic               step_en_o,     // Step 15 included.
	output logic [2:0]         gain_o,        // Gain factor 1, 2 or 4.
	output logic [3:0]         pos_sel_o,     // Positive input code.
	output logic               auto_neg_o,    // Negative input chosen internally.
	output logic               neg_ch7_o      // Negative input is channel 7.
);

	// Reset words held as vectors, since a literal cannot be indexed directly.
	localparam logic [15:0] STEP_RST = `MSR_STEP_RESET;
	localparam logic [15:0] SP1_RST  = `MSR_SPARE1_RESET;
	localparam logic [15:0] SP2_RST  = `MSR_SPARE2_RESET;

	// Reset image of the whole state.
	localparam msr_pkg::msr_state_type RESET_STATE = '{
		cfg_en:      STEP_RST[`MSR_EN_BIT],
		cfg_gain:    msr_pkg::msr_gain_type'(STEP_RST[`MSR_GAIN_MSB:`MSR_GAIN_LSB]),
		cfg_neg:     STEP_RST[`MSR_NEG_BIT],
		cfg_pos:     STEP_RST[`MSR_POS_MSB:`MSR_POS_LSB],
		sp1_hi:      SP1_RST[`MSR_SP1_HI_MSB:`MSR_SP1_HI_LSB],
		sp1_lo:      SP1_RST[`MSR_SP1_LO_MSB:`MSR_SP1_LO_LSB],
		sp2:         SP2_RST,
		ack:         1'b0,
		rdata:       32'h0000_0000,
		out_en:      STEP_RST[`MSR_EN_BIT],
		out_gain:    3'h1,
		out_neg_ch7: 1'b0,
		out_auto:    STEP_RST[`MSR_AUTO_BIT],
		out_pos:     STEP_RST[`MSR_POS_MSB:`MSR_POS_LSB]
	};

	msr_pkg::msr_state_type st;
	msr_pkg::msr_state_type next_st;

	// Word index from a byte address; low two bits are ignored.
	function automatic logic [7:0] word_idx(input logic [AW-1:0] adr);
		word_idx = adr[9:2];
	endfunction

	// Byte-lane merge of a 16-bit register image with write data.
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [15:0] wr_val,
		input logic [1:0]  sel
	);
		lane_merge[7:0]  = sel[0] ? wr_val[7:0] : old_val[7:0];
		lane_merge[15:8] = sel[1] ? wr_val[15:8] : old_val[15:8];
	endfunction

	// Gain factor for a gain code; both upper codes mean four.
	function automatic logic [2:0] gain_factor(input msr_pkg::msr_gain_type code);
		unique case (code)
			msr_pkg::MSR_GAIN_X1:  gain_factor = 3'h1;
			msr_pkg::MSR_GAIN_X2:  gain_factor = 3'h2;
			msr_pkg::MSR_GAIN_X4A: gain_factor = 3'h4;
			msr_pkg::MSR_GAIN_X4B: gain_factor = 3'h4;
		endcase
	endfunction

	// Register images as software sees them.
	logic [15:0] step_word;
	logic [15:0] sp1_word;
	logic        req;
	logic [7:0]  idx;

	// Reserved fields are built in as constants, so no write can reach them.
	always_comb begin
		step_word = 16'h0000;
		step_word[`MSR_EN_BIT] = st.cfg_en;
		step_word[`MSR_GAIN_MSB:`MSR_GAIN_LSB] = st.cfg_gain;
		step_word[`MSR_NEG_BIT] = st.cfg_neg;
		step_word[`MSR_POS_MSB:`MSR_POS_LSB] = st.cfg_pos;
		sp1_word = `MSR_SP1_FIXED;
		sp1_word[`MSR_SP1_HI_MSB:`MSR_SP1_HI_LSB] = st.sp1_hi;
		sp1_word[`MSR_SP1_LO_MSB:`MSR_SP1_LO_LSB] = st.sp1_lo;
	end

	assign req = cyc_i && stb_i;
	assign idx = word_idx(adr_i);

	// Next state: answer one cycle after a request, commit writes at the ack edge.
	always_comb begin
		logic [15:0] merged;
		merged = 16'h0000;
		next_st = st;
		next_st.ack = 1'b0;
		// Ack is held off in the cycle after it, so each request is answered once.
		if (req && !st.ack) begin
			next_st.ack = 1'b1;
			unique case (idx)
				`MSR_STEP_IDX:   next_st.rdata = {16'h0000, step_word};
				`MSR_SPARE1_IDX: next_st.rdata = {16'h0000, sp1_word};
				`MSR_SPARE2_IDX: next_st.rdata = {16'h0000, st.sp2};
				default:         next_st.rdata = 32'h0000_0000;
			endcase
		end
		// Writes land on the edge where the master sees ack; unmapped ones are dropped.
		if (req && st.ack && we_i) begin
			unique case (idx)
				`MSR_STEP_IDX: begin
					merged = lane_merge(step_word, dat_i[15:0], sel_i[1:0]);
					next_st.cfg_en = merged[`MSR_EN_BIT];
					next_st.cfg_gain = msr_pkg::msr_gain_type'(
						merged[`MSR_GAIN_MSB:`MSR_GAIN_LSB]);
					next_st.cfg_neg = merged[`MSR_NEG_BIT];
					next_st.cfg_pos = merged[`MSR_POS_MSB:`MSR_POS_LSB];
				end
				`MSR_SPARE1_IDX: begin
					merged = lane_merge(sp1_word, dat_i[15:0], sel_i[1:0]);
					next_st.sp1_hi = merged[`MSR_SP1_HI_MSB:`MSR_SP1_HI_LSB];
					next_st.sp1_lo = merged[`MSR_SP1_LO_MSB:`MSR_SP1_LO_LSB];
				end
				`MSR_SPARE2_IDX: begin
					next_st.sp2 = lane_merge(st.sp2, dat_i[15:0], sel_i[1:0]);
				end
				default: begin
					merged = 16'h0000;
				end
			endcase
		end
		// Steering outputs follow the stored fields so they leave a flip-flop.
		next_st.out_en = next_st.cfg_en;
		next_st.out_gain = gain_factor(next_st.cfg_gain);
		next_st.out_pos = next_st.cfg_pos;
		next_st.out_auto = next_st.cfg_pos[`MSR_AUTO_BIT];
		// Internal sources pick their own negative input; the select bit is moot.
		next_st.out_neg_ch7 = next_st.cfg_neg && !next_st.out_auto;
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign dat_o      = st.rdata;
	assign ack_o      = st.ack;
	assign step_en_o  = st.out_en;
	assign gain_o     = st.out_gain;
	assign pos_sel_o  = st.out_pos;
	assign auto_neg_o = st.out_auto;
	assign neg_ch7_o  = st.out_neg_ch7;

	// Checks on the bus handshake, on what the fields steer, on reserved and reset values and on the spare words.

	property p_ack_single;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

	property p_ack_cause;
		@(posedge clk_i) disable iff (rst_i)
		$rose(ack_o) |-> $past(cyc_i && stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");

	property p_en_write;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_STEP_IDX && sel_i[1])
			|=> step_en_o == $past(dat_i[15]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("step enable not written");

	property p_gain_map;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_STEP_IDX && sel_i[1])
			|=> gain_o == ($past(dat_i[14]) ? 3'h4 : ($past(dat_i[13]) ? 3'h2 : 3'h1));
	endproperty
	a_gain_map: assert property (p_gain_map) else $error("gain factor wrong");

	property p_step_rsvd;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && !we_i && idx == `MSR_STEP_IDX) |-> dat_o[12:5] == 8'h00;
	endproperty
	a_step_rsvd: assert property (p_step_rsvd) else $error("step reserved bits not zero");

	property p_neg_sel;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_STEP_IDX && sel_i[0])
			|=> neg_ch7_o == ($past(dat_i[4]) && !$past(dat_i[3]));
	endproperty
	a_neg_sel: assert property (p_neg_sel) else $error("negative input wrong");

	property p_auto_neg;
		@(posedge clk_i) disable iff (rst_i)
		auto_neg_o == pos_sel_o[3] && !(auto_neg_o && neg_ch7_o);
	endproperty
	a_auto_neg: assert property (p_auto_neg) else $error("auto negative overridden");

	property p_reset_val;
		@(posedge clk_i)
		$fell(rst_i) |-> pos_sel_o == 4'hf && !step_en_o && gain_o == 3'h1
			&& !neg_ch7_o && st.sp1_lo == 2'h1 && st.sp2 == 16'h0000;
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("reset values wrong");

	property p_sp1_fixed;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && !we_i && idx == `MSR_SPARE1_IDX)
			|-> dat_o[15:12] == 4'h0 && dat_o[9:6] == 4'h8 && dat_o[3:0] == 4'h0;
	endproperty
	a_sp1_fixed: assert property (p_sp1_fixed) else $error("spare one fixed bits wrong");

	property p_sp1_store;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_SPARE1_IDX && sel_i[0])
			|=> st.sp1_lo == $past(dat_i[5:4]);
	endproperty
	a_sp1_store: assert property (p_sp1_store) else $error("spare one not stored");

	property p_sp2_store;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_SPARE2_IDX && sel_i[1:0] == 2'h3)
			|=> st.sp2 == $past(dat_i[15:0]);
	endproperty
	a_sp2_store: assert property (p_sp2_store) else $error("spare two not stored");

	// Further checks on the answer timing, on field writes and on fields the bus leaves alone.

	property p_ack_latency;
		@(posedge clk_i) disable iff (rst_i)
		(req && !ack_o) |=> ack_o;
	endproperty
	a_ack_latency: assert property (p_ack_latency) else $error("request not answered in time");

	property p_rdata_upper;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |-> dat_o[31:16] == 16'h0000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read half not zero");

	property p_pos_write;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_STEP_IDX && sel_i[0])
			|=> pos_sel_o == $past(dat_i[3:0]);
	endproperty
	a_pos_write: assert property (p_pos_write) else $error("positive input not written");

	property p_auto_src;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_STEP_IDX && sel_i[0])
			|=> auto_neg_o == $past(dat_i[3]);
	endproperty
	a_auto_src: assert property (p_auto_src) else $error("internal source not flagged");

	property p_sp1_hi_store;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i && idx == `MSR_SPARE1_IDX && sel_i[1])
			|=> st.sp1_hi == $past(dat_i[11:10]);
	endproperty
	a_sp1_hi_store: assert property (p_sp1_hi_store) else $error("spare one high not stored");

	// Any write at all must leave every fixed position at its fixed value.
	property p_rsvd_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(ack_o && req && we_i)
			|=> step_word[12:5] == 8'h00 && (sp1_word & 16'hf3cf) == `MSR_SP1_FIXED;
	endproperty
	a_rsvd_ignored: assert property (p_rsvd_ignored) else $error("reserved bits written");

	property p_gain_legal;
		@(posedge clk_i) disable iff (rst_i)
		gain_o == 3'h1 || gain_o == 3'h2 || gain_o == 3'h4;
	endproperty
	a_gain_legal: assert property (p_gain_legal) else $error("gain factor not 1, 2 or 4");

	// Steering moves only on a committed step write; reset edges fall under the disable.
	property p_en_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ack_o && req && we_i && idx == `MSR_STEP_IDX)
			|=> $stable(step_en_o) && $stable(pos_sel_o)
			&& $stable(gain_o);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("steering changed without a write");

endmodule

// ### rtl/msr_regs.svh
// Register offsets, field positions, reset values and fixed patterns of the step and spare slice.
`ifndef MSR_REGS_SVH
`define MSR_REGS_SVH

// Word indexes; the byte address on the bus is four times the index.
`define MSR_STEP_IDX      8'h9f
`define MSR_SPARE1_IDX    8'ha0
`define MSR_SPARE2_IDX    8'ha1

// Last-step configuration word fields.
`define MSR_EN_BIT        15
`define MSR_GAIN_MSB      14
`define MSR_GAIN_LSB      13
`define MSR_NEG_BIT       4
`define MSR_POS_MSB       3
`define MSR_POS_LSB       0
`define MSR_AUTO_BIT      3

// First spare word fields.
`define MSR_SP1_HI_MSB    11
`define MSR_SP1_HI_LSB    10
`define MSR_SP1_LO_MSB    5
`define MSR_SP1_LO_LSB    4
`define MSR_SP1_FIXED     16'h0200

// Reset values.
`define MSR_STEP_RESET    16'h000f
`define MSR_SPARE1_RESET  16'h0210
`define MSR_SPARE2_RESET  16'h0000

`endif

// ### verif/tb_top.sv
// Self-checking bench for the step and spare register slice over classic Wishbone.
`include "msr_regs.svh"

`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp); end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [9:0]  adr_i = 10'h000;
	logic [31:0] dat_i = 32'h0;
	logic [3:0]  sel_i = 4'h0;
	logic        we_i  = 1'b0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        step_en_o;
	logic [2:0]  gain_o;
	logic [3:0]  pos_sel_o;
	logic        auto_neg_o;
	logic        neg_ch7_o;
	int          n_mismatch = 0;
	int          check_count = 0;
	logic [31:0] q;
	logic [15:0] w;

	msr_regbank msr_regbank_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.step_en_o(step_en_o), .gain_o(gain_o), .pos_sel_o(pos_sel_o),
		.auto_neg_o(auto_neg_o), .neg_ch7_o(neg_ch7_o));

	// Free-running 250 MHz clock.
	always #2 clk_i = ~clk_i;

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Holds reset for twenty cycles; used at start and again in mid-run.
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// One classic cycle; a dead slave is caught by the watchdog, not by this task.
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [15:0] wd,
		input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= wr;
		adr_i <= {idx, 2'b00};
		sel_i <= sel;
		dat_i <= {16'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		`CHK(n, 2, "ack latency")
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	// Reads a word and compares it with the expected 16-bit value.
	task automatic chk_rd(input logic [7:0] idx, input logic [15:0] exp, input string msg);
		bus(idx, 1'b0, 16'h0, 4'h3);
		`CHK(q, {16'h0, exp}, msg)
	endtask

	// Compares the steering outputs with what the step word v commands.
	task automatic chk_steer(input logic [15:0] v);
		logic [2:0] g;
		g = (v[14:13] == 2'h0) ? 3'h1 : ((v[14:13] == 2'h1) ? 3'h2 : 3'h4);
		`CHK(step_en_o, v[15], "enable")
		`CHK(gain_o, g, "gain factor")
		`CHK(pos_sel_o, v[3:0], "positive input")
		`CHK(auto_neg_o, v[3], "automatic negative")
		`CHK(neg_ch7_o, v[4] & ~v[3], "negative channel 7")
	endtask

	// Main sequence.
	initial begin
		do_reset();
		chk_rd(`MSR_STEP_IDX, 16'h000f, "step reset");
		chk_steer(16'h000f);
		chk_rd(`MSR_SPARE1_IDX, 16'h0210, "spare one reset");
		chk_rd(`MSR_SPARE2_IDX, 16'h0000, "spare two reset");
		// Every positive code, every gain code, both enable values; reserved bits written as ones.
		for (int i = 0; i < 16; i++) begin
			w = {i[0], i[2:1], 8'hff, ~i[2], i[3:0]};
			bus(`MSR_STEP_IDX, 1'b1, w, 4'h3);
			chk_rd(`MSR_STEP_IDX, w & 16'he01f, "step readback");
			chk_steer(w);
		end
		// Writing the low lane alone must leave the high lane's fields untouched.
		bus(`MSR_STEP_IDX, 1'b1, 16'hffff, 4'h3);
		bus(`MSR_STEP_IDX, 1'b1, 16'h0000, 4'h1);
		chk_rd(`MSR_STEP_IDX, 16'he000, "step low lane");
		chk_steer(16'he000);
		bus(`MSR_SPARE1_IDX, 1'b1, 16'hffff, 4'h3);
		chk_rd(`MSR_SPARE1_IDX, 16'h0e30, "spare one ones");
		bus(`MSR_SPARE1_IDX, 1'b1, 16'h0000, 4'h3);
		chk_rd(`MSR_SPARE1_IDX, 16'h0200, "spare one zeros");
		bus(`MSR_SPARE2_IDX, 1'b1, 16'ha5c3, 4'h3);
		chk_rd(`MSR_SPARE2_IDX, 16'ha5c3, "spare two word");
		bus(`MSR_SPARE2_IDX, 1'b1, 16'h00ff, 4'h1);
		chk_rd(`MSR_SPARE2_IDX, 16'ha5ff, "spare two low lane");
		// Unmapped word answers with zero and must not disturb its neighbour.
		bus(8'ha2, 1'b1, 16'hffff, 4'h3);
		chk_rd(8'ha2, 16'h0000, "unmapped read");
		chk_rd(`MSR_SPARE2_IDX, 16'ha5ff, "spare two kept");
		do_reset();
		chk_rd(`MSR_STEP_IDX, 16'h000f, "step second reset");
		chk_steer(16'h000f);
		final_report();
	end

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		#40000;
		n_mismatch++;
		final_report();
	end
endmodule
